// >>> core/cax_core.sv
// Purpose: decode and execution of arithmetic, branch, bit and control opcodes
// Assumes: program and data memories answer a registered address in the same cycle
// Notes: load and store encodings and interrupt entry live elsewhere
// Operation
// - add/and/compare/subtract: accumulator with memory or immediate
// - clear/inc/dec work on all 256 data bytes
// - complement and rotate act on accumulator only
// - conditional branch jumps only if condition holds
// - flag branches: 5-bit displacement, -15 to +16
// - bit-test branches: byte displacement, -126 to +129
// - bit-test copies tested bit to carry
// - branch-if-bit-clear: three bytes, five cycles
// - branch-if-bit-set: three bytes, five cycles
// - bit set/clear any bit, flags kept
// - long jump and call reach all 12 bits
// - stop acts as wait under watchdog
// - extended target: opcode nibble then next byte
// - relative opcode: condition, direction, four-bit magnitude
// - opcode bit 4 picks index register
`timescale 1ns/10ps
`include "cax_map.svh"
module cax_core
  import cax_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // program space
  output logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  // data space
  output logic [7:0] data_addr_o,
  output logic [7:0] data_wdata_o,
  output logic data_we_o,
  input wire logic [7:0] data_rdata_i,
  // system
  input wire logic wdg_sel_i,
  input wire logic wake_i,
  input wire logic flag_save_i,
  // state
  output logic [7:0] acc_o,
  output logic zero_flag_o,
  output logic carry_flag_o,
  output logic wait_mode_o,
  output logic stop_mode_o
);

  cax_state_e state_q, state_d;
  cax_class_e cls_q, cls_d;
  logic [2:0] len_q, len_d, cnt_q, cnt_d;
  logic [11:0] pc_q, pc_d, ia_q, ia_d;
  logic [7:0] ir_q, ir_d, b2_q, b2_d, ea_q, ea_d, acc_q, acc_d;
  logic [7:0] daddr_q, daddr_d, wdata_q, wdata_d;
  logic we_q, we_d, z_q, z_d, c_q, c_d, zs_q, zs_d, cs_q, cs_d;
  logic wait_q, wait_d, stop_q, stop_d;
  logic [2:0] sp_q, sp_d;
  logic [11:0] stk [0:5];
  logic push, pop;
  logic [11:0] push_val, top_val;
  logic [2:0] push_idx;

  cax_alu_op_e alu_op;
  logic [7:0] opnd, alu_res, bit_mask;
  logic alu_z, alu_c, taken, tested;
  logic [1:0] md;
  logic [2:0] fn, bsel;

  // decode of a fresh opcode into instruction class
  function automatic cax_class_e classify(input logic [7:0] op);
    cax_class_e k;
    k = CL_NOP;
    if (op == `CAX_OP_NO_OPERATION) k = CL_NOP;
    else if (op[0] == 1'b0) k = CL_REL;
    else if (op[3:0] == `CAX_LO_CALL) k = CL_CALL;
    else if (op[3:0] == `CAX_LO_LONG_JUMP) k = CL_JUMP;
    else if (op[3:0] == `CAX_LO_BIT_TEST) k = CL_BT;
    else if (op[3:0] == `CAX_LO_BIT_MOD) k = CL_BIT;
    else if (op[2:0] == `CAX_LO3_ALU) begin
      if (op[7:5] == 3'h4) k = CL_NOP;
      else if (op[4:3] == `CAX_MD_IMMED && (op[7:5] == `CAX_FN_INC ||
               op[7:5] == `CAX_FN_DEC || op[7:5] == `CAX_FN_CLR)) k = CL_NOP;
      else k = CL_ALU;
    end
    else if (op[3:0] == `CAX_LO_INC_SD && op[5:4] == 2'h1) k = CL_INC_SD;
    else if (op[3:0] == `CAX_LO_DEC_SD && op[5:4] == 2'h1) k = CL_DEC_SD;
    else if (op == `CAX_OP_COMPLEMENT) k = CL_COM;
    else if (op == `CAX_OP_ROTATE) k = CL_RLC;
    else if (op == `CAX_OP_RETURN_INT) k = CL_RETURN_FROM_INTERRUPT;
    else if (op == `CAX_OP_RETURN_SUB) k = CL_RET;
    else if (op == `CAX_OP_WAIT) k = CL_WAIT;
    else if (op == `CAX_OP_STOP) k = CL_STOP;
    return k;
  endfunction : classify

  assign md = ir_q[4:3];
  assign fn = ir_q[7:5];
  assign bsel = {ir_q[5], ir_q[6], ir_q[7]};
  assign bit_mask = 8'h01 << bsel;
  assign top_val = stk[(sp_q == 3'h0) ? 3'h0 : sp_q - 3'h1];
  assign push_idx = (sp_q == `CAX_STACK_DEPTH) ? `CAX_STACK_TOP : sp_q;
  // immediate operand sits in program space, all others in data space
  assign opnd = (cls_q == CL_ALU && md == `CAX_MD_IMMED) ? b2_q :
                (ea_q == `CAX_ACC_ADDR) ? acc_q : data_rdata_i;
  assign tested = |(opnd & bit_mask);

  always_comb begin
    alu_op = ALU_CP;
    case (cls_q)
      CL_INC_SD: alu_op = ALU_INC;
      CL_DEC_SD: alu_op = ALU_DEC;
      CL_COM: alu_op = ALU_COM;
      CL_RLC: alu_op = ALU_RLC;
      CL_ALU: begin
        case (fn)
          `CAX_FN_ADD: alu_op = ALU_ADD;
          `CAX_FN_SUB: alu_op = ALU_SUB;
          `CAX_FN_AND: alu_op = ALU_AND;
          `CAX_FN_INC: alu_op = ALU_INC;
          `CAX_FN_DEC: alu_op = ALU_DEC;
          `CAX_FN_CLR: alu_op = ALU_CLR;
          default: alu_op = ALU_CP;
        endcase
      end
      default: alu_op = ALU_CP;
    endcase
  end

  cax_alu u_alu (
    .op_i(alu_op),
    .carry_i(c_q),
    .a_i(acc_q),
    .b_i(opnd),
    .res_o(alu_res),
    .zero_o(alu_z),
    .carry_o(alu_c)
  );

  // condition of the one-byte branches: op[2:1] picks flag pair
  always_comb begin
    case (ir_q[2:1])
      2'h0: taken = ~z_q;
      2'h1: taken = ~c_q;
      2'h2: taken = z_q;
      default: taken = c_q;
    endcase
  end

  always_comb begin
    state_d = state_q;
    cls_d = cls_q;
    len_d = len_q;
    cnt_d = cnt_q + 3'h1;
    pc_d = pc_q;
    ia_d = ia_q;
    ir_d = ir_q;
    b2_d = b2_q;
    ea_d = ea_q;
    acc_d = acc_q;
    daddr_d = daddr_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    z_d = z_q;
    c_d = c_q;
    zs_d = flag_save_i ? z_q : zs_q;
    cs_d = flag_save_i ? c_q : cs_q;
    wait_d = wait_q;
    stop_d = stop_q;
    sp_d = sp_q;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_q;
    case (state_q)
      ST_FETCH: begin
        ir_d = prog_data_i;
        ia_d = pc_q;
        pc_d = pc_q + 12'h001;
        cnt_d = 3'h1;
        cls_d = classify(prog_data_i);
        len_d = `CAX_LEN_STD;
        state_d = ST_BYTE2;
        case (classify(prog_data_i))
          CL_BT: len_d = `CAX_LEN_BT;
          CL_REL, CL_NOP, CL_RET, CL_RETURN_FROM_INTERRUPT, CL_WAIT, CL_STOP: begin
            len_d = `CAX_LEN_CTL;
            state_d = ST_EXEC;
          end
          CL_COM, CL_RLC: state_d = ST_EXEC;
          CL_INC_SD, CL_DEC_SD: begin
            ea_d = {`CAX_SD_BASE, prog_data_i[7:6]};
            daddr_d = {`CAX_SD_BASE, prog_data_i[7:6]};
            state_d = ST_EXEC;
          end
          CL_ALU: begin
            if (prog_data_i[`CAX_DIR_BIT] == 1'b0) begin
              daddr_d = prog_data_i[`CAX_IDX_SEL_BIT] ?
                        `CAX_IDX_Y_ADDR : `CAX_IDX_X_ADDR;
              state_d = ST_PTR;
            end
          end
          default: state_d = ST_BYTE2;
        endcase
      end
      ST_BYTE2: begin
        b2_d = prog_data_i;
        ea_d = prog_data_i;
        daddr_d = prog_data_i;
        pc_d = pc_q + 12'h001;
        state_d = (cls_q == CL_BT) ? ST_BYTE3 : ST_EXEC;
      end
      ST_BYTE3: begin
        b2_d = prog_data_i;
        pc_d = pc_q + 12'h001;
        state_d = ST_EXEC;
      end
      ST_PTR: begin
        ea_d = data_rdata_i;
        daddr_d = data_rdata_i;
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = (cnt_q == len_q - 3'h1) ? ST_FETCH : ST_PAD;
        case (cls_q)
          CL_REL: begin
            if (taken) begin
              pc_d = ir_q[`CAX_DIR_BIT] ? ia_q - {8'h00, ir_q[7:4]} :
                     ia_q + 12'h001 + {8'h00, ir_q[7:4]};
            end
          end
          CL_BT: begin
            c_d = tested;
            if (tested == ir_q[`CAX_SENSE_BIT]) begin
              pc_d = ia_q + 12'h002 + {{4{b2_q[7]}}, b2_q};
            end
          end
          CL_BIT: begin
            we_d = (ea_q != `CAX_ACC_ADDR);
            wdata_d = ir_q[`CAX_SENSE_BIT] ? (opnd | bit_mask) :
                      (opnd & ~bit_mask);
            if (ea_q == `CAX_ACC_ADDR) acc_d = wdata_d;
          end
          CL_JUMP, CL_CALL: begin
            pc_d = {ir_q[7:4], b2_q};
            push = (cls_q == CL_CALL);
            sp_d = (push && sp_q != `CAX_STACK_DEPTH) ? sp_q + 3'h1 : sp_q;
          end
          CL_RET, CL_RETURN_FROM_INTERRUPT: begin
            pop = 1'b1;
            pc_d = top_val;
            sp_d = (sp_q == 3'h0) ? 3'h0 : sp_q - 3'h1;
            if (cls_q == CL_RETURN_FROM_INTERRUPT) begin
              z_d = zs_q;
              c_d = cs_q;
            end
          end
          CL_WAIT, CL_STOP: begin
            wait_d = (cls_q == CL_WAIT) || wdg_sel_i;
            stop_d = (cls_q == CL_STOP) && !wdg_sel_i;
            state_d = ST_SLEEP;
          end
          CL_COM, CL_RLC: begin
            acc_d = alu_res;
            z_d = alu_z;
            c_d = alu_c;
          end
          CL_INC_SD, CL_DEC_SD: begin
            we_d = 1'b1;
            wdata_d = alu_res;
            z_d = alu_z;
          end
          CL_ALU: begin
            case (fn)
              `CAX_FN_CP: begin
                z_d = alu_z;
                c_d = alu_c;
              end
              `CAX_FN_INC, `CAX_FN_DEC, `CAX_FN_CLR: begin
                we_d = (ea_q != `CAX_ACC_ADDR);
                wdata_d = alu_res;
                if (ea_q == `CAX_ACC_ADDR) acc_d = alu_res;
                if (fn != `CAX_FN_CLR) z_d = alu_z;
                else if (ea_q == `CAX_ACC_ADDR) begin
                  z_d = alu_z;
                  c_d = alu_c;
                end
              end
              default: begin
                acc_d = alu_res;
                z_d = alu_z;
                c_d = alu_c;
              end
            endcase
          end
          default: acc_d = acc_q;
        endcase
      end
      ST_PAD: begin
        if (cnt_q == len_q - 3'h1) state_d = ST_FETCH;
      end
      ST_SLEEP: begin
        cnt_d = cnt_q;
        if (wake_i) begin
          wait_d = 1'b0;
          stop_d = 1'b0;
          state_d = ST_FETCH;
        end
      end
      default: state_d = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_FETCH;
      cls_q <= CL_NOP;
      len_q <= `CAX_LEN_CTL;
      cnt_q <= 3'h0;
      pc_q <= `CAX_RESET_PC;
      ia_q <= `CAX_RESET_PC;
      ir_q <= 8'h00;
      b2_q <= 8'h00;
      ea_q <= 8'h00;
      acc_q <= 8'h00;
      daddr_q <= 8'h00;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      z_q <= 1'b0;
      c_q <= 1'b0;
      zs_q <= 1'b0;
      cs_q <= 1'b0;
      wait_q <= 1'b0;
      stop_q <= 1'b0;
      sp_q <= 3'h0;
    end else if (ce_i) begin
      state_q <= state_d;
      cls_q <= cls_d;
      len_q <= len_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      ia_q <= ia_d;
      ir_q <= ir_d;
      b2_q <= b2_d;
      ea_q <= ea_d;
      acc_q <= acc_d;
      daddr_q <= daddr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      z_q <= z_d;
      c_q <= c_d;
      zs_q <= zs_d;
      cs_q <= cs_d;
      wait_q <= wait_d;
      stop_q <= stop_d;
      sp_q <= sp_d;
    end
  end

  // overflowing calls overwrite the top slot (CAX_STACK_TOP) rather than wrap
  always_ff @(posedge clock_i) begin
    if (ce_i && push) stk[push_idx] <= push_val;
  end

  assign prog_addr_o = pc_q;
  assign data_addr_o = daddr_q;
  assign data_wdata_o = wdata_q;
  assign data_we_o = we_q;
  assign acc_o = acc_q;
  assign zero_flag_o = z_q;
  assign carry_flag_o = c_q;
  assign wait_mode_o = wait_q;
  assign stop_mode_o = stop_q;

endmodule : cax_core

// >>> include/cax_map.svh
// Purpose: address, field and timing constants of the execution core
// Assumes: included by bare name wherever a constant is needed
// Notes: types live in cax_pkg
`ifndef CAX_MAP_SVH
`define CAX_MAP_SVH

// data space locations and reset address
`define CAX_ACC_ADDR 8'hFF
`define CAX_IDX_X_ADDR 8'h80
`define CAX_IDX_Y_ADDR 8'h81
`define CAX_SD_BASE 6'h20
`define CAX_RESET_PC 12'hFFE

// return address stack
`define CAX_STACK_DEPTH 3'h6
`define CAX_STACK_TOP 3'h5

// instruction lengths in clock cycles
`define CAX_LEN_STD 3'h4
`define CAX_LEN_BT 3'h5
`define CAX_LEN_CTL 3'h2

// single-byte control opcodes
`define CAX_OP_NO_OPERATION 8'h04
`define CAX_OP_COMPLEMENT 8'h2D
`define CAX_OP_ROTATE 8'hAD
`define CAX_OP_RETURN_INT 8'h4D
`define CAX_OP_RETURN_SUB 8'hCD
`define CAX_OP_STOP 8'h6D
`define CAX_OP_WAIT 8'hED

// opcode low nibbles
`define CAX_LO_CALL 4'h1
`define CAX_LO_LONG_JUMP 4'h9
`define CAX_LO_BIT_TEST 4'h3
`define CAX_LO_BIT_MOD 4'hB
`define CAX_LO_INC_SD 4'h5
`define CAX_LO_DEC_SD 4'hD
`define CAX_LO3_ALU 3'h7

// opcode field positions
`define CAX_IDX_SEL_BIT 4
`define CAX_DIR_BIT 3
`define CAX_SENSE_BIT 4

// arithmetic group function field
`define CAX_FN_CLR 3'h0
`define CAX_FN_CP 3'h1
`define CAX_FN_ADD 3'h2
`define CAX_FN_INC 3'h3
`define CAX_FN_AND 3'h5
`define CAX_FN_SUB 3'h6
`define CAX_FN_DEC 3'h7

// arithmetic group addressing field
`define CAX_MD_DIRECT 2'h1
`define CAX_MD_IMMED 2'h3

`endif

// >>> include/cax_pkg.sv
// Purpose: types shared by the execution core and its arithmetic unit
// Assumes: nothing
// Notes: state codes are one-hot
package cax_pkg;

  typedef enum logic [6:0] {
    ST_FETCH = 7'b0000001,
    ST_BYTE2 = 7'b0000010,
    ST_BYTE3 = 7'b0000100,
    ST_PTR   = 7'b0001000,
    ST_EXEC  = 7'b0010000,
    ST_PAD   = 7'b0100000,
    ST_SLEEP = 7'b1000000
  } cax_state_e;

  typedef enum logic [3:0] {
    CL_NOP, CL_REL, CL_BT, CL_BIT, CL_JUMP, CL_CALL, CL_ALU, CL_INC_SD,
    CL_DEC_SD, CL_RET, CL_RETURN_FROM_INTERRUPT, CL_WAIT, CL_STOP, CL_COM, CL_RLC
  } cax_class_e;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_CP, ALU_AND, ALU_INC, ALU_DEC, ALU_CLR, ALU_COM,
    ALU_RLC
  } cax_alu_op_e;

endpackage : cax_pkg

// >>> core/cax_alu.sv
// Purpose: combinational arithmetic and logic unit of the core
// Assumes: a is the accumulator, b the second or memory operand
// Notes: carry after subtract and compare is the borrow
`timescale 1ns/10ps
module cax_alu
  import cax_pkg::*;
(
  // operation
  input wire cax_alu_op_e op_i,
  input wire logic carry_i,
  // operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  // result
  output logic [7:0] res_o,
  output logic zero_o,
  output logic carry_o
);

  logic [8:0] wide;

  always_comb begin
    wide = 9'h000;
    res_o = 8'h00;
    carry_o = carry_i;
    case (op_i)
      ALU_ADD: begin
        wide = {1'b0, a_i} + {1'b0, b_i};
        res_o = wide[7:0];
        carry_o = wide[8];
      end
      ALU_SUB, ALU_CP: begin
        wide = {1'b0, a_i} - {1'b0, b_i};
        res_o = wide[7:0];
        carry_o = wide[8];
      end
      ALU_AND: res_o = a_i & b_i;
      ALU_INC: res_o = b_i + 8'h01;
      ALU_DEC: res_o = b_i - 8'h01;
      ALU_CLR: begin
        res_o = 8'h00;
        carry_o = 1'b0;
      end
      ALU_COM: begin
        res_o = ~a_i;
        carry_o = a_i[7];
      end
      ALU_RLC: begin
        res_o = {a_i[6:0], carry_i};
        carry_o = a_i[7];
      end
      default: res_o = 8'h00;
    endcase
    zero_o = (res_o == 8'h00);
  end

endmodule : cax_alu

// >>> bench/cax_mem.sv
// Purpose: program and data memories facing the execution core
// Assumes: asynchronous reads, writes taken on the clock while enabled
// Notes: the bench loads contents by hierarchical reference
`timescale 1ns/10ps
module cax_mem (
  // clock
  input wire logic clock_i,
  input wire logic ce_i,
  // program space
  input wire logic [11:0] prog_addr_i,
  output logic [7:0] prog_data_o,
  // data space
  input wire logic [7:0] data_addr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic data_we_i,
  output logic [7:0] data_rdata_o
);
  logic [7:0] prog [4096];
  logic [7:0] dmem [256];
  assign prog_data_o = prog[prog_addr_i];
  assign data_rdata_o = dmem[data_addr_i];
  // a strobe held under a stalled clock writes nothing until ce_i returns
  always @(posedge clock_i) begin
    if (data_we_i && ce_i) begin
      dmem[data_addr_i] <= data_wdata_i;
    end
  end
endmodule : cax_mem

// >>> bench/cax_core_monitor.sv
// Purpose: concurrent checks on the execution core ports
// Assumes: bound to cax_core, one clock domain
// Notes: write strobe, sleep modes and flag keeping
`timescale 1ns/10ps
module cax_core_monitor (
  // clock and control
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wdg_sel_i,
  input wire logic wake_i,
  // core outputs
  input wire logic [11:0] prog_addr_o,
  input wire logic [7:0] data_addr_o,
  input wire logic data_we_o,
  input wire logic [7:0] acc_o,
  input wire logic zero_flag_o,
  input wire logic carry_flag_o,
  input wire logic wait_mode_o,
  input wire logic stop_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_we_pulse;
    data_we_o && ce_i |=> !data_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  property p_we_not_acc;
    data_we_o |-> data_addr_o != 8'hFF;
  endproperty
  a_we_not_acc: assert property (p_we_not_acc) else $error("write to accumulator");
  property p_ce_freeze;
    !ce_i |=> $stable(prog_addr_o) && $stable(acc_o) && $stable(data_we_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("moved while disabled");
  property p_stop_wdg;
    $rose(stop_mode_o) |-> !$past(wdg_sel_i);
  endproperty
  a_stop_wdg: assert property (p_stop_wdg) else $error("stop under watchdog");
  property p_sleep_hold;
    (wait_mode_o || stop_mode_o) && !wake_i && ce_i |=> $stable({wait_mode_o, stop_mode_o});
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep unwoken");
  property p_sleep_wake;
    (wait_mode_o || stop_mode_o) && wake_i && ce_i |=> !wait_mode_o && !stop_mode_o;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("wake ignored");
  property p_we_carry;
    data_we_o |-> $stable(carry_flag_o);
  endproperty
  a_we_carry: assert property (p_we_carry) else $error("carry moved on write");
  property p_sleep_flags;
    wait_mode_o || stop_mode_o |-> $stable(carry_flag_o) && $stable(zero_flag_o);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("flags moved asleep");
endmodule : cax_core_monitor

bind cax_core cax_core_monitor u_cax_core_monitor (.clock_i, .rst_i, .ce_i, .wdg_sel_i,
  .wake_i, .prog_addr_o, .data_addr_o, .data_we_o, .acc_o, .zero_flag_o, .carry_flag_o,
  .wait_mode_o, .stop_mode_o);

// >>> bench/cpu_alu_branch_control_exec_tb.sv
// Purpose: self-checking bench for the execution core
// Assumes: program loaded at 010h, reset vector jumps there
// Notes: each program ends in a jump to itself; writes are checked from a queue
`timescale 1ns/10ps
module cpu_alu_branch_control_exec_tb;
  logic clock_i, rst_i, ce_i, hold_ce, wdg_sel_i, wake_i, flag_save_i, data_we_o;
  logic [11:0] prog_addr_o;
  logic [7:0] prog_data_i, data_addr_o, data_wdata_o, data_rdata_i, acc_o;
  logic zero_flag_o, carry_flag_o, wait_mode_o, stop_mode_o;
  logic [15:0] exp_q[$];
  logic [7:0] alu_op [12] = '{8'h4F, 8'h5F, 8'hAF, 8'hBF, 8'h2F, 8'h3F, 8'hCF, 8'hDF,
                              8'h2D, 8'hAD, 8'h4F, 8'h57};
  int bad_count, compares;
  integer seed;
  cax_core u_cax_core (.clock_i, .rst_i, .ce_i, .prog_addr_o, .prog_data_i, .data_addr_o,
    .data_wdata_o, .data_we_o, .data_rdata_i, .wdg_sel_i, .wake_i, .flag_save_i, .acc_o,
    .zero_flag_o, .carry_flag_o, .wait_mode_o, .stop_mode_o);
  cax_mem u_cax_mem (.clock_i, .ce_i, .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
    .data_addr_i(data_addr_o), .data_wdata_i(data_wdata_o), .data_we_i(data_we_o),
    .data_rdata_o(data_rdata_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // random stalls shake every timing path; hold_ce forces a run cycle
  always @(negedge clock_i) ce_i <= hold_ce | (($random(seed) & 3) != 0);
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  always @(posedge clock_i) begin
    if (data_we_o === 1'b1 && ce_i === 1'b1) begin
      if (exp_q.size() > 0) chk("write", {data_addr_o, data_wdata_o}, exp_q.pop_front());
      else chk("extra write", {data_addr_o, data_wdata_o}, ~{data_addr_o, data_wdata_o});
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic run(input logic [7:0] code[$], input logic [11:0] end_a,
                     input logic [9:0] st, input logic [1:0] slp);
    int n;
    logic woke;
    rst_i = 1'b1;
    wake_i = 1'b0;
    woke = 1'b0;
    foreach (code[i]) u_cax_mem.prog[12'h010 + i] = code[i];
    u_cax_mem.prog[end_a] = 8'h09;
    u_cax_mem.prog[end_a + 12'h001] = end_a[7:0];
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    for (n = 0; n < 3000 && prog_addr_o !== end_a; n++) begin
      @(negedge clock_i);
      if ((wait_mode_o | stop_mode_o) === 1'b1 && !woke) begin
        chk("sleep", {14'h0000, wait_mode_o, stop_mode_o}, {14'h0000, slp});
        hold_ce = 1'b1;
        @(negedge clock_i);
        flag_save_i = 1'b1;
        @(negedge clock_i);
        flag_save_i = 1'b0;
        hold_ce = 1'b0;
        wake_i = 1'b1;
        woke = 1'b1;
      end
    end
    chk("end reached", {4'h0, prog_addr_o}, {4'h0, end_a});
    repeat (12) @(negedge clock_i);
    chk("acc flags", {6'h00, zero_flag_o, carry_flag_o, acc_o}, {6'h00, st});
    chk("writes left", 16'(exp_q.size()), 16'h0000);
    chk("woke", {15'h0000, woke}, {15'h0000, slp != 2'b00});
    exp_q.delete();
  endtask : run
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
  initial begin
    logic [7:0] a, b, rr, m, d, x, op;
    logic [8:0] s;
    logic [7:0] q[$];
    logic z, c, t;
    int j, n;
    seed = 32'hCB39;
    {rst_i, hold_ce, wdg_sel_i, wake_i, flag_save_i} = 5'h10;
    bad_count = 0;
    compares = 0;
    for (int i = 0; i < 256; i++) u_cax_mem.dmem[i] = 8'($random(seed));
    for (int i = 0; i < 4096; i++) u_cax_mem.prog[i] = 8'h04;
    u_cax_mem.prog[12'hFFE] = 8'h09;
    u_cax_mem.prog[12'hFFF] = 8'h10;
    for (int k = 0; k < 24; k++) begin
      j = k / 2;
      a = 8'($random(seed));
      b = k[0] ? 8'(-a) : 8'($random(seed));
      rr = 8'h20 | 8'($random(seed) & 31);
      u_cax_mem.dmem[rr] = b;
      u_cax_mem.dmem[8'h81] = rr;
      if (j == 10) b = a;
      q = '{8'h0F, 8'hFF, 8'h5F, a, alu_op[j]};
      if (j < 8) q.push_back(j[0] ? b : rr);
      if (j == 10) q.push_back(8'hFF);
      case (j)
        2, 3: s = {1'b0, a & b};
        4, 5, 6, 7: s = {1'b0, a} - {1'b0, b};
        8: s = {a[7], ~a};
        9: s = {a[7], a[6:0], 1'b0};
        default: s = {1'b0, a} + {1'b0, b};
      endcase
      z = (s[7:0] == 8'h00);
      if (j == 4 || j == 5) s[7:0] = a;
      run(q, 12'h010 + 12'(q.size()), {z, s}, 2'b00);
    end
    $display("test arithmetic done");
    for (int k = 0; k < 2; k++) begin
      rr = 8'h40 | 8'($random(seed) & 15);
      m = 8'h50 | 8'($random(seed) & 15);
      x = 8'h60 | 8'($random(seed) & 15);
      a = 8'($random(seed));
      b = 8'($random(seed));
      d = k ? 8'hFF : 8'($random(seed));
      u_cax_mem.dmem[rr] = a;
      u_cax_mem.dmem[m] = b;
      u_cax_mem.dmem[8'h80] = m;
      u_cax_mem.dmem[8'h83] = d;
      exp_q = '{{rr, a + 8'h01}, {m, b - 8'h01}, {x, 8'h00}, {8'h83, d + 8'h01}};
      run('{8'h3F, 8'h01, 8'h6F, rr, 8'hE7, 8'h0F, x, 8'hD5}, 12'h018,
          {d == 8'hFF, 1'b1, 8'h00}, 2'b00);
    end
    $display("test memory operand done");
    for (int k = 0; k < 16; k++) begin
      rr = 8'h20 | 8'($random(seed) & 31);
      x = 8'h40 | 8'($random(seed) & 31);
      m = 8'h60 | 8'($random(seed) & 31);
      a = 8'($random(seed));
      b = 8'($random(seed));
      d = 8'($random(seed) & 127);
      u_cax_mem.dmem[rr] = a;
      u_cax_mem.dmem[x] = b;
      u_cax_mem.dmem[m] = d;
      c = a[k[2:0]];
      t = (c == k[3]);
      exp_q.push_back({x, k[3] ? b | (8'h01 << k[2:0]) : b & ~(8'h01 << k[2:0])});
      if (!t) exp_q.push_back({m, d + 8'h01});
      op = {k[0], k[1], k[2], k[3], 4'h3};
      run('{8'h3F, 8'h01, {op[7:4], 4'hB}, x, op, rr, 8'h03, 8'h6F, m}, 12'h019,
          {1'b0, c, 8'h00}, 2'b00);
    end
    $display("test bit operations done");
    for (int k = 0; k < 8; k++) begin
      n = k[0] ? 15 : 2;
      m = 8'h60 | 8'($random(seed) & 31);
      d = 8'($random(seed) & 127);
      u_cax_mem.dmem[m] = d;
      t = (k[2:1] == 2'b00) || (k[2:1] == 2'b11);
      q = '{8'h3F, 8'h01, {4'(n), 1'b0, k[2:1], 1'b0}, 8'h6F, m};
      while (q.size() < n + 3) q.push_back(8'h04);
      if (!t) exp_q.push_back({m, d + 8'h01});
      run(q, 12'h013 + 12'(n), {2'b01, 8'h00}, 2'b00);
    end
    for (int k = 0; k < 2; k++) begin
      m = 8'h60 | 8'($random(seed) & 31);
      x = 8'h40 | 8'($random(seed) & 31);
      d = 8'($random(seed) & 127);
      b = 8'($random(seed) & 127);
      u_cax_mem.dmem[m] = d;
      u_cax_mem.dmem[x] = b;
      u_cax_mem.prog[12'hA34] = 8'h6F;
      u_cax_mem.prog[12'hA35] = x;
      u_cax_mem.prog[12'hA36] = 8'hCD;
      u_cax_mem.prog[12'hF00] = 8'h09;
      u_cax_mem.prog[12'hF01] = 8'h1C;
      exp_q.push_back({x, b + 8'h01});
      if (k) exp_q.push_back({m, d + 8'h01});
      q = '{8'h3F, 8'h01, 8'hA1, 8'h34, 8'hF9, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04,
            8'h04, k ? 8'h4C : 8'h4E, 8'h6F, m, 8'h09, 8'h18};
      // end address lies off the sequential path so the poll cannot stop early
      run(q, 12'h018, {2'b01, 8'h00}, 2'b00);
    end
    $display("test branches done");
    for (int k = 0; k < 3; k++) begin
      wdg_sel_i = (k == 1);
      q = '{8'h3F, 8'h01, k ? 8'h6D : 8'hED, 8'h0F, 8'hFF, 8'h01, 8'h30};
      while (q.size() < 32) q.push_back(8'h04);
      q.push_back(8'h4D);
      run(q, 12'h017, {2'b01, 8'h00}, k == 2 ? 2'b01 : 2'b10);
    end
    $display("test sleep done");
    close_out();
  end
endmodule : cpu_alu_branch_control_exec_tb
